/* File: core/boot_check_pkg.sv */
// constants shared by the boot stream checker and its word fifo
package boot_check_pkg;
    localparam logic [31:0] MAGIC_WORD     = 32'h41504954;
    localparam logic [23:0] CMD_PREFIX     = 24'h585359;
    localparam logic [31:0] CRC_POLY       = 32'h04c11db7;
    localparam logic [31:0] CRC_INIT       = 32'h00000000;
    localparam logic [31:0] ERR_CODE_ADDR  = 32'h10000708;
    localparam logic [31:0] REV_ID_ADDR    = 32'h0000000c;
    localparam logic [31:0] WORK_AREA_LO   = 32'h10000400;
    localparam logic [31:0] WORK_AREA_HI   = 32'h10000fff;
    localparam logic [3:0]  ERR_KEYWORD    = 4'h1;
    localparam logic [3:0]  ERR_SYNC       = 4'h2;
    localparam logic [3:0]  ERR_CRC        = 4'h3;
    localparam logic [3:0]  ERR_BOOTMODE   = 4'h5;
    localparam logic [3:0]  ERR_NONE       = 4'h0;
    localparam logic [7:0]  OP_SECTION_LD  = 8'h01;
    localparam logic [7:0]  OP_REQ_CRC     = 8'h02;
    localparam logic [7:0]  OP_PING        = 8'h03;
    localparam logic [7:0]  OP_JUMP_CLOSE  = 8'h04;
    localparam int          WORD_W         = 32;
    localparam int          FIFO_WORDS     = 32;
    localparam logic [4:0]  LAST_BIT_IDX   = 5'h1f;
    localparam logic [5:0]  FULL_WORD_BITS = 6'h20;
    localparam logic [31:0] WORD_BYTES     = 32'h00000004;
endpackage

/* File: core/word_stream_if.sv */
// valid/ready word stream between the checker and its fifo
interface word_stream_if #(parameter int WIDTH = 32) ();
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: core/word_fifo.sv */
// synchronous word fifo with valid/ready on both sides
module word_fifo
    import boot_check_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = FIFO_WORDS
) (
    // clock and reset
    input  wire logic   ref_clk_in,
    input  wire logic   reset_in,
    // streams
    word_stream_if.snk  fill,
    word_stream_if.src  drain
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
        $error("word_fifo depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifo_state_t;

    fifo_state_t s_r;
    fifo_state_t s_nxt;
    logic        push;
    logic        pop;

    // honest flags straight from the occupancy count
    assign fill.ready  = (s_r.cnt != (AW+1)'(DEPTH));
    assign drain.valid = (s_r.cnt != '0);
    assign drain.data  = s_r.mem[s_r.rp];
    assign push        = fill.valid && fill.ready;
    assign pop         = drain.valid && drain.ready;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = fill.data;
            s_nxt.wp          = s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        case ({push, pop})
            2'b10:   s_nxt.cnt = s_r.cnt + 1'b1;
            2'b01:   s_nxt.cnt = s_r.cnt - 1'b1;
            default: s_nxt.cnt = s_r.cnt;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

/* File: core/boot_stream_checker.sv */
// boot image stream checker: word assembly, sync checks, running crc, abort handling
//
// Operation
// - in master modes the first word must equal the magic value or the boot aborts with code 1.
// - on any failure the error code is stored at the fixed error location and the block halts for good.
// - error codes are 1 keyword, 2 transmit sync, 3 crc mismatch, 5 unsupported boot mode.
// - every command word must carry the command prefix in its upper 24 bits or the boot aborts with code 2.
// - a command is expected after the magic word, after a ping, and after any other finished command except jump-close, which ends in done.
// - serial words arrive most significant bit first and are assembled in that order.
// - a crc request compares the carried value with the running crc and aborts with code 3 on mismatch.
// - the crc shifts left per data bit, inserts the bit at bit 0 and xors the polynomial when a one falls out.
// - each section feeds the crc with its load address, then its byte size, then its data words.
// - whole words go first, and a trailing 1 to 3 bytes are the low 8, 16 or 24 bits of the last word.
// - the crc starts at zero and runs across all sections without reset between them.
// - a 32-bit boot revision identifier reads back at its fixed rom location.
// - the instruction cache is disabled at boot start and never invalidated or re-enabled here.
module boot_stream_checker
    import boot_check_pkg::*;
#(
    parameter int          FIFO_DEPTH = FIFO_WORDS,
    parameter logic [31:0] REV_ID     = 32'h0001_0203   // arbitrary value
) (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    // boot control
    input  wire logic        boot_start_in,
    input  wire logic        boot_master_in,
    input  wire logic        boot_mode_ok_in,
    // serial bit stream
    input  wire logic        bit_in,
    input  wire logic        bit_valid_in,
    output logic             bit_ready_out,
    // section data towards the loader
    input  wire logic        sink_stall_in,
    output logic [31:0]      data_word_out,
    output logic             data_valid_out,
    // error report
    output logic             err_flag_out,
    output logic [3:0]       err_code_out,
    output logic             err_wr_out,
    output logic [31:0]      err_addr_out,
    output logic [31:0]      err_data_out,
    // status
    output logic             boot_done_out,
    output logic             icache_disable_out,
    output logic [31:0]      crc_out,
    // rom read port
    input  wire logic        rom_rd_in,
    input  wire logic [31:0] rom_addr_in,
    output logic [31:0]      rom_data_out
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_MAGIC = 9'h002,
        ST_CMD   = 9'h004,
        ST_ADDR  = 9'h008,
        ST_SIZE  = 9'h010,
        ST_DATA  = 9'h020,
        ST_CRCW  = 9'h040,
        ST_DONE  = 9'h080,
        ST_HALT  = 9'h100
    } chk_state_t;

    typedef struct packed {
        chk_state_t  st;
        logic [31:0] sh;
        logic [4:0]  bcnt;
        logic        pend;
        logic [31:0] crc;
        logic [31:0] rem;
        logic        err;
        logic [3:0]  code;
        logic        err_wr;
        logic        cache_off;
        logic [31:0] dword;
        logic        dvalid;
        logic [31:0] rom_q;
    } ctl_t;

    ctl_t s_r;
    ctl_t s_nxt;

    word_stream_if #(.WIDTH(WORD_W)) fill_if ();
    word_stream_if #(.WIDTH(WORD_W)) drain_if ();

    logic        take;
    logic [31:0] word;

    ////////////////////////////////////////////////////////////////////////////
    // crc over the low nbits of data, msb of that field first
    function automatic logic [31:0] checksum_update_step(input logic [31:0] crc,
                                                         input logic [31:0] data,
                                                         input logic [5:0]  nbits);
        logic [31:0] c;
        logic        msb;
        c   = crc;
        msb = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if (i < int'(nbits)) begin
                msb = c[31];
                c   = {c[30:0], data[i]};
                if (msb) begin
                    c = c ^ CRC_POLY;
                end
            end
        end
        return c;
    endfunction

    // single place that turns any failure into a halt
    function automatic ctl_t abort_to(input ctl_t s, input logic [3:0] code);
        ctl_t t;
        t        = s;
        t.err    = 1'b1;
        t.code   = code;
        t.err_wr = 1'b1;
        t.st     = ST_HALT;
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // the fifo decouples the serial side from the checker so a stalled
    // loader back-pressures the link instead of dropping words
    word_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .fill       (fill_if.snk),
        .drain      (drain_if.src)
    );

    assign fill_if.valid  = s_r.pend;
    assign fill_if.data   = s_r.sh;
    assign bit_ready_out  = !s_r.pend;
    assign word           = drain_if.data;
    assign drain_if.ready = !sink_stall_in &&
                            (s_r.st inside {ST_MAGIC, ST_CMD, ST_ADDR, ST_SIZE, ST_DATA, ST_CRCW});
    assign take           = drain_if.valid && drain_if.ready;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt        = s_r;
        s_nxt.err_wr = 1'b0;
        s_nxt.dvalid = 1'b0;

        // word assembly; a full word blocks new bits until the fifo takes it
        if (bit_valid_in && !s_r.pend) begin
            s_nxt.sh   = {s_r.sh[30:0], bit_in};
            s_nxt.bcnt = s_r.bcnt + 5'h01;
            if (s_r.bcnt == LAST_BIT_IDX) begin
                s_nxt.pend = 1'b1;
            end
        end
        if (s_r.pend && fill_if.ready) begin
            s_nxt.pend = 1'b0;
        end

        if (rom_rd_in) begin
            s_nxt.rom_q = (rom_addr_in == REV_ID_ADDR) ? REV_ID : 32'h00000000;
        end

        case (s_r.st)
            ST_IDLE: begin
                if (boot_start_in) begin
                    s_nxt.cache_off = 1'b1;
                    s_nxt.crc       = CRC_INIT;
                    if (!boot_mode_ok_in) begin
                        s_nxt = abort_to(s_nxt, ERR_BOOTMODE);
                    end else if (boot_master_in) begin
                        s_nxt.st = ST_MAGIC;
                    end else begin
                        s_nxt.st = ST_CMD;
                    end
                end
            end
            ST_MAGIC: begin
                if (take) begin
                    if (word != MAGIC_WORD) begin
                        s_nxt = abort_to(s_nxt, ERR_KEYWORD);
                    end else begin
                        s_nxt.st = ST_CMD;
                    end
                end
            end
            ST_CMD: begin
                if (take) begin
                    if (word[31:8] != CMD_PREFIX) begin
                        s_nxt = abort_to(s_nxt, ERR_SYNC);
                    end else begin
                        case (word[7:0])
                            OP_SECTION_LD: s_nxt.st = ST_ADDR;
                            OP_REQ_CRC:    s_nxt.st = ST_CRCW;
                            OP_JUMP_CLOSE: s_nxt.st = ST_DONE;
                            OP_PING:       s_nxt.st = ST_CMD;
                            default:       s_nxt.st = ST_CMD;
                        endcase
                    end
                end
            end
            ST_ADDR: begin
                if (take) begin
                    s_nxt.crc = checksum_update_step(s_r.crc, word, FULL_WORD_BITS);
                    s_nxt.st  = ST_SIZE;
                end
            end
            ST_SIZE: begin
                if (take) begin
                    s_nxt.crc = checksum_update_step(s_r.crc, word, FULL_WORD_BITS);
                    s_nxt.rem = word;
                    s_nxt.st  = (word == 32'h00000000) ? ST_CMD : ST_DATA;
                end
            end
            ST_DATA: begin
                if (take) begin
                    s_nxt.dword  = word;
                    s_nxt.dvalid = 1'b1;
                    if (s_r.rem >= WORD_BYTES) begin
                        s_nxt.crc = checksum_update_step(s_r.crc, word, FULL_WORD_BITS);
                        s_nxt.rem = s_r.rem - WORD_BYTES;
                    end else begin
                        s_nxt.crc = checksum_update_step(s_r.crc, word, {1'b0, s_r.rem[1:0], 3'b000});
                        s_nxt.rem = 32'h00000000;
                    end
                    if (s_r.rem <= WORD_BYTES) begin
                        s_nxt.st = ST_CMD;
                    end
                end
            end
            ST_CRCW: begin
                if (take) begin
                    if (word != s_r.crc) begin
                        s_nxt = abort_to(s_nxt, ERR_CRC);
                    end else begin
                        s_nxt.st = ST_CMD;
                    end
                end
            end
            ST_DONE: begin
                s_nxt.st = ST_DONE;
            end
            ST_HALT: begin
                s_nxt.st = ST_HALT;
            end
            default: begin
                s_nxt.st = ST_HALT;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_r      <= '0;
            s_r.st   <= ST_IDLE;
            s_r.code <= ERR_NONE;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign data_word_out      = s_r.dword;
    assign data_valid_out     = s_r.dvalid;
    assign err_flag_out       = s_r.err;
    assign err_code_out       = s_r.code;
    assign err_wr_out         = s_r.err_wr;
    assign err_addr_out       = ERR_CODE_ADDR;
    assign err_data_out       = {28'h0000000, s_r.code};
    assign boot_done_out      = (s_r.st == ST_DONE);
    assign icache_disable_out = s_r.cache_off;
    assign crc_out            = s_r.crc;
    assign rom_data_out       = s_r.rom_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    // one write of the code, then silence with the flag raised
    sequence seq_abort(logic [3:0] c);
        err_wr_out && err_code_out == c && err_flag_out ##1 !err_wr_out && err_flag_out;
    endsequence

    sequence seq_word_in(chk_state_t st);
        take && s_r.st == st;
    endsequence

    a_magic_check: assert property (seq_word_in(ST_MAGIC) and word != MAGIC_WORD |=> seq_abort(ERR_KEYWORD))
        else $error("bad magic word did not abort with code 1");
    a_prefix_check: assert property (seq_word_in(ST_CMD) and word[31:8] != CMD_PREFIX |=> seq_abort(ERR_SYNC))
        else $error("bad command prefix did not abort with code 2");
    a_crc_compare: assert property (seq_word_in(ST_CRCW) and word != s_r.crc |=> seq_abort(ERR_CRC))
        else $error("crc mismatch did not abort with code 3");
    a_mode_check: assert property (s_r.st == ST_IDLE && boot_start_in && !boot_mode_ok_in |=> seq_abort(ERR_BOOTMODE))
        else $error("unsupported mode did not abort with code 5");
    a_err_location: assert property (err_wr_out |-> err_addr_out == ERR_CODE_ADDR && err_data_out[3:0] == err_code_out)
        else $error("error code written to wrong place");
    a_halt_sticky: assert property (err_flag_out |=> err_flag_out && $stable(err_code_out) && !boot_done_out)
        else $error("error report changed after abort");
    a_next_command: assert property (seq_word_in(ST_MAGIC) and word == MAGIC_WORD |=> s_r.st == ST_CMD)
        else $error("no command expected after magic word");
    a_addr_crc: assert property (seq_word_in(ST_ADDR) |=>
                                 crc_out == checksum_update_step($past(s_r.crc), $past(word), FULL_WORD_BITS))
        else $error("address not folded into crc");
    a_tail_bytes: assert property (seq_word_in(ST_DATA) and s_r.rem < WORD_BYTES |=>
            crc_out == checksum_update_step($past(s_r.crc), $past(word), {1'b0, $past(s_r.rem[1:0]), 3'b000})
            && s_r.st == ST_CMD)
        else $error("trailing bytes handled wrongly");
    a_msb_first: assert property ($rose(s_r.pend) |-> s_r.sh[0] == $past(bit_in) && s_r.sh[31:1] == $past(s_r.sh[30:0]))
        else $error("serial word not assembled msb first");
    a_cache_held: assert property ($rose(icache_disable_out) |=> icache_disable_out [*8])
        else $error("instruction cache re-enabled");
    a_rev_read: assert property (rom_rd_in && rom_addr_in == REV_ID_ADDR |=> rom_data_out == REV_ID)
        else $error("revision identifier not returned");
endmodule

/* File: tb/boot_source_model.sv */
// serial boot memory model: shifts queued words out msb first
module boot_source_model (
    // clock
    input  wire logic ref_clk_in,
    // bit link
    input  wire logic ready_in,
    output logic      bit_out,
    output logic      valid_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] words[$];
    int          idx = 31;

    initial begin
        bit_out = 1'b0;
        valid_out = 1'b0;
    end

    task automatic flush();
        words.delete();
        idx = 31;
    endtask

    always @(posedge ref_clk_in) begin
        // a flush can empty the queue while a stale bit is still offered
        if (valid_out && ready_in && words.size() != 0) begin
            if (idx == 0) begin
                void'(words.pop_front());
                idx = 31;
            end else begin
                idx--;
            end
        end
        #1;
        if (words.size() != 0) begin
            valid_out = 1'b1;
            bit_out = words[0][idx];
        end else begin
            // idle line toggles so a stale bit is never mistaken for data
            valid_out = 1'b0;
            bit_out = ~bit_out;
        end
    end
endmodule

/* File: tb/boot_stream_checker_tb.sv */
// self-checking bench for the boot stream checker
module boot_stream_checker_tb import boot_check_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        start = 1'b0;
    logic        master = 1'b0;
    logic        mode_ok = 1'b1;
    logic        stall = 1'b0;
    logic        rom_rd = 1'b0;
    logic [31:0] rom_addr = 32'h00000000;
    logic        bit_line, bit_valid, bit_ready, data_valid, err_flag, err_wr, done, icache;
    logic [31:0] data_word, err_addr, err_data, crc, rom_data;
    logic [3:0]  err_code;
    logic [31:0] dv_words[$];
    int          wr_cnt, cycles, failures, total_checks;
    localparam logic [31:0] REV = 32'h00a5_5a01; // arbitrary value

    always #12.5 ref_clk = ~ref_clk;

    boot_source_model boot_source_model_i (.ref_clk_in(ref_clk), .ready_in(bit_ready), .bit_out(bit_line),
        .valid_out(bit_valid));

    boot_stream_checker #(.REV_ID(REV)) boot_stream_checker_i (
        .ref_clk_in(ref_clk), .reset_in(reset), .boot_start_in(start), .boot_master_in(master),
        .boot_mode_ok_in(mode_ok), .bit_in(bit_line), .bit_valid_in(bit_valid), .bit_ready_out(bit_ready),
        .sink_stall_in(stall), .data_word_out(data_word), .data_valid_out(data_valid),
        .err_flag_out(err_flag), .err_code_out(err_code), .err_wr_out(err_wr), .err_addr_out(err_addr),
        .err_data_out(err_data), .boot_done_out(done), .icache_disable_out(icache), .crc_out(crc),
        .rom_rd_in(rom_rd), .rom_addr_in(rom_addr), .rom_data_out(rom_data));

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // pulse monitor and hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (data_valid === 1'b1) dv_words.push_back(data_word);
        if (err_wr === 1'b1) wr_cnt++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [31:0] d, input int nbits);
        logic m;
        for (int i = nbits - 1; i >= 0; i--) begin
            m = c[31];
            c = {c[30:0], d[i]};
            if (m) c = c ^ CRC_POLY;
        end
        return c;
    endfunction

    task automatic do_reset();
        @(posedge ref_clk);
        #1 reset = 1'b1;
        boot_source_model_i.flush();
        repeat (12) @(posedge ref_clk);
        #1 reset = 1'b0;
        dv_words.delete();
        wr_cnt = 0;
    endtask

    task automatic start_boot(input logic m, input logic ok);
        @(posedge ref_clk);
        #1 start = 1'b1;
        master = m;
        mode_ok = ok;
        @(posedge ref_clk);
        #1 start = 1'b0;
    endtask

    task automatic push(input logic [31:0] w);
        boot_source_model_i.words.push_back(w);
    endtask

    task automatic wait_end();
        int n;
        for (n = 0; n < 5000 && done !== 1'b1 && err_flag !== 1'b1; n++) @(posedge ref_clk);
        #2;
        check_flag(n < 5000, 1'b1, "boot finished");
    endtask

    task automatic test_reset_rom();
        do_reset();
        check_flag(err_flag, 1'b0, "flag at reset");
        check_word(err_addr, ERR_CODE_ADDR, "error location");
        check_flag(icache, 1'b0, "cache idle");
        @(posedge ref_clk);
        #1 rom_rd = 1'b1;
        rom_addr = REV_ID_ADDR;
        @(posedge ref_clk);
        #1 rom_addr = 32'h00000010;
        check_word(rom_data, REV, "revision word");
        @(posedge ref_clk);
        #1 rom_rd = 1'b0;
        check_word(rom_data, 32'h00000000, "other rom word");
        $display("test reset_rom ended");
    endtask

    task automatic test_good_master();
        logic [31:0] c;
        do_reset();
        start_boot(1'b1, 1'b1);
        c = crc_upd(CRC_INIT, 32'h80001000, 32);
        c = crc_upd(c, 32'h00000005, 32);
        c = crc_upd(c, 32'hcafef00d, 32);
        c = crc_upd(c, 32'h123456a7, 8);
        c = crc_upd(c, 32'h80002000, 32);
        c = crc_upd(c, 32'h00000004, 32);
        c = crc_upd(c, 32'h0badbeef, 32);
        push(MAGIC_WORD);
        push({CMD_PREFIX, OP_SECTION_LD});
        push(32'h80001000);
        push(32'h00000005);
        push(32'hcafef00d);
        push(32'h123456a7);
        push({CMD_PREFIX, OP_SECTION_LD});
        push(32'h80002000);
        push(32'h00000004);
        push(32'h0badbeef);
        push({CMD_PREFIX, OP_PING});
        push({CMD_PREFIX, OP_REQ_CRC});
        push(c);
        push({CMD_PREFIX, OP_JUMP_CLOSE});
        wait_end();
        check_flag(done, 1'b1, "done");
        check_flag(err_flag, 1'b0, "no error");
        check_word(crc, c, "running crc");
        check_flag(icache, 1'b1, "cache disabled");
        check_word(32'(dv_words.size()), 32'h00000003, "data words");
        check_word(dv_words[0], 32'hcafef00d, "first data word");
        check_word(dv_words[2], 32'h0badbeef, "third data word");
        check_word(32'(wr_cnt), 32'h00000000, "error writes");
        $display("test good_master ended");
    endtask

    task automatic test_stall_slave();
        stall = 1'b1;
        do_reset();
        start_boot(1'b0, 1'b1);
        for (int i = 0; i < 40; i++) push({CMD_PREFIX, OP_PING});
        push({CMD_PREFIX, OP_JUMP_CLOSE});
        repeat (1500) @(posedge ref_clk);
        #2;
        check_flag(bit_ready, 1'b0, "full buffer refuses bits");
        check_flag(done, 1'b0, "held by stall");
        @(posedge ref_clk);
        #1 stall = 1'b0;
        wait_end();
        check_flag(done, 1'b1, "slave done");
        check_word(crc, CRC_INIT, "crc untouched");
        $display("test stall_slave ended");
    endtask

    task automatic abort_case(input logic m, input logic ok, input logic [31:0] w[3], input int n,
                              input logic [3:0] code);
        do_reset();
        start_boot(m, ok);
        for (int i = 0; i < n; i++) push(w[i]);
        wait_end();
        repeat (40) @(posedge ref_clk);
        #2;
        check_flag(err_flag, 1'b1, "error flag held");
        check_word({28'h0000000, err_code}, {28'h0000000, code}, "error code");
        check_word(err_data, {28'h0000000, code}, "stored code");
        check_word(32'(wr_cnt), 32'h00000001, "one error write");
        check_flag(done, 1'b0, "halted");
    endtask

    task automatic test_aborts();
        abort_case(1'b1, 1'b1, '{32'h41504955, 32'h0, 32'h0}, 1, ERR_KEYWORD);
        abort_case(1'b1, 1'b1, '{MAGIC_WORD, 32'h58535a01, 32'h0}, 2, ERR_SYNC);
        abort_case(1'b1, 1'b1, '{MAGIC_WORD, {CMD_PREFIX, OP_REQ_CRC}, 32'h1}, 3, ERR_CRC);
        abort_case(1'b1, 1'b0, '{32'h0, 32'h0, 32'h0}, 0, ERR_BOOTMODE);
        $display("test aborts ended");
    endtask

    initial begin
        test_reset_rom();
        test_good_master();
        test_stall_slave();
        test_aborts();
        conclude();
    end
endmodule
